// ---- pkg/digital_input_event_counter_map.svh ----
// address map, field positions, reset values and timing of the event counter card
// assumes byte addressing on a 32-bit AXI4-Lite bus, one word per register
`ifndef DIGITAL_INPUT_EVENT_COUNTER_MAP_SVH
`define DIGITAL_INPUT_EVENT_COUNTER_MAP_SVH

// page select is addr[11:6], word select addr[5:2]
`define PAGE_MSB 11
`define PAGE_LSB 6
`define WORD_MSB 5
`define WORD_LSB 2
`define PAGE_IN_POINT 6'h01
`define PAGE_OUT_POINT 6'h05
`define PAGE_COUNT 6'h09
`define PAGE_PRESET 6'h0A
`define PAGE_IN_FIELD 6'h0B
`define PAGE_OUT_FIELD 6'h0C
`define PAGE_ROLLOVER 6'h0D
`define PAGE_SENSE 6'h0E
`define PAGE_UNMASK 6'h0F
`define PAGE_CARD 6'h10

// word indexes inside pages
`define WORD_FIRST 4'h0
`define WORD_SECOND 4'h1
`define WORD_THIRD 4'h2
`define WORD_FOURTH 4'h3
`define WORD_FIFTH 4'h4

// card_strobe_configuration bits
`define CFG_EXT_BIT 0
`define CFG_RISE_BIT 8

// reset values and counter limits
`define RST_FIELD 16'h0000
`define RST_COUNT 8'h00
`define RST_CFG 32'h0000_0000
`define COUNT_MAX 8'hFF
`define COUNT_ZERO 8'h00

// bus responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// scan timing
`define POINTS 16
`define SCAN_PERIOD_NS 16000
`define CLK_MHZ 40

`endif

// ---- pkg/dio_pkg.sv ----
// types shared by the event counter card
// assumes the map header for all numeric constants
package dio_pkg;
  typedef logic [31:0] word_type;
  typedef logic [15:0] field_type;
  typedef logic [7:0] count_type;
  typedef logic [3:0] point_type;
endpackage

// ---- logic/digital_input_event_counter.sv ----
// sixteen-point input and output field with event counters and strobed input latching
// assumes one 40 MHz clock, field pins and strobe asynchronous, AXI4-Lite master
//
// The register addresses and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/1ps
`include "digital_input_event_counter_map.svh"

// Summary of operation
// - override bit set: every input change of the point is an event
// - override clear: change counts only if new level equals sense bit
// - points scanned in turn, each once per 16 us, strobe independent
// - rollover bit set: counter reloads its preset on overflow
// - rollover bit clear: counter wraps to zero and keeps counting
// - after wrapping, next overflow needs another 256 events
// - event arriving at count 255 raises a scaled event for the point
// - scaled event recorded only when the point's unmask bit is 1
// - first record after clear sets flag; enable gates it to processor
// - record holds one sticky bit per point, no count of events
// - reading the record returns it and clears it, keeping only bits set in the read cycle
// - configuration bit 0 selects internal or external strobe
// - configuration bit 8 picks rising or falling external strobe edge
// - read with internal strobe latches present inputs and returns them
// - read without strobe returns stored data; strobes locked until read
// - reading stored input data re-enables strobing
// - external strobe replaces internal one; ignored while data unread
// - status bit 0 is 1 while waiting for a strobe, data was read
// - per-point input addresses return current input value
// - per-point output write drives the point from data bit 0
// - per-point output read returns the driven value
// - counts readable, presets writable and readable per point
// - whole input field and whole output field readable
module digital_input_event_counter #(
  parameter dio_pkg::word_type CARD_ID = 32'h0000_5A5A // arbitrary value
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic awvalid,
  output logic awready,
  input wire logic [11:0] awaddr,
  input wire logic [2:0] awprot,
  // axi4-lite write data
  input wire logic wvalid,
  output logic wready,
  input wire dio_pkg::word_type wdata,
  input wire logic [3:0] wstrb,
  // axi4-lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // axi4-lite read address
  input wire logic arvalid,
  output logic arready,
  input wire logic [11:0] araddr,
  input wire logic [2:0] arprot,
  // axi4-lite read data
  output logic rvalid,
  input wire logic rready,
  output dio_pkg::word_type rdata,
  output logic [1:0] rresp,
  // field pins
  input wire dio_pkg::field_type field_in,
  input wire logic ext_strobe,
  output dio_pkg::field_type field_out,
  // processor interrupt
  output logic card_irq
);
  import dio_pkg::*;

  localparam int STEP_NS = `SCAN_PERIOD_NS / `POINTS;
  localparam int STEP_CYCLES = STEP_NS * `CLK_MHZ / 1000;
  localparam logic [5:0] STEP_LAST = 6'(STEP_CYCLES - 1);

  // ---------------------------------------------
  // pin synchronisers
  // ---------------------------------------------
  field_type in_m_r;
  field_type in_s_r;
  logic ext_m_r;
  logic ext_s_r;
  logic ext_d_r;

  always_ff @(posedge aclk)
  begin
    in_m_r <= field_in;
    in_s_r <= in_m_r;
    ext_m_r <= ext_strobe;
    ext_s_r <= ext_m_r;
    ext_d_r <= ext_s_r;
  end

  wire ext_rise = ext_s_r & ~ext_d_r;
  wire ext_fall = ~ext_s_r & ext_d_r;

  // ---------------------------------------------
  // registers
  // ---------------------------------------------
  field_type out_r;
  field_type roll_r;
  field_type sense_r;
  field_type ovr_r;
  field_type unmask_r;
  field_type rec_r;
  field_type past_r;
  field_type stored_r;
  word_type cfg_r;
  logic inten_r;
  logic flag_r;
  logic full_r;
  logic irq_r;
  count_type [15:0] count_r;
  count_type [15:0] preset_r;
  logic [5:0] step_r;
  point_type scan_r;

  // ---------------------------------------------
  // axi write channel capture
  // ---------------------------------------------
  logic aw_got_r;
  logic w_got_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic [11:0] waddr_r;
  word_type wdata_r;
  logic [3:0] wstrb_r;

  assign awready = ~aw_got_r & ~bvalid_r;
  assign wready = ~w_got_r & ~bvalid_r;
  assign bvalid = bvalid_r;
  assign bresp = bresp_r;
  wire aw_fire = awvalid & awready;
  wire w_fire = wvalid & wready;
  wire wr_fire = aw_got_r & w_got_r & ~bvalid_r;

  function automatic logic mapped(input logic [5:0] pg, input logic [3:0] wd);
    mapped = (pg == `PAGE_IN_POINT) || (pg == `PAGE_OUT_POINT) || (pg == `PAGE_COUNT) ||
             (pg == `PAGE_PRESET) ||
             ((pg == `PAGE_IN_FIELD) && (wd <= `WORD_THIRD)) ||
             ((pg == `PAGE_OUT_FIELD || pg == `PAGE_ROLLOVER || pg == `PAGE_UNMASK) && (wd == `WORD_FIRST)) ||
             ((pg == `PAGE_SENSE) && (wd <= `WORD_SECOND)) ||
             ((pg == `PAGE_CARD) && (wd <= `WORD_FIFTH));
  endfunction

  function automatic field_type merge16(input field_type old, input word_type nw, input logic [1:0] st);
    merge16 = {st[1] ? nw[15:8] : old[15:8], st[0] ? nw[7:0] : old[7:0]};
  endfunction

  wire [5:0] wpage = waddr_r[`PAGE_MSB:`PAGE_LSB];
  wire [3:0] widx = waddr_r[`WORD_MSB:`WORD_LSB];
  wire wr_ok = mapped(wpage, widx);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= `RESP_OKAY;
      waddr_r <= 12'h000;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
    end
    else
    begin
      if (aw_fire)
      begin
        aw_got_r <= 1'b1;
        waddr_r <= awaddr;
      end
      if (w_fire)
      begin
        w_got_r <= 1'b1;
        wdata_r <= wdata;
        wstrb_r <= wstrb;
      end
      if (wr_fire)
      begin
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (bvalid_r && bready)
        bvalid_r <= 1'b0;
    end
  end

  // ---------------------------------------------
  // write decode
  // ---------------------------------------------
  wire w_first = wr_fire && widx == `WORD_FIRST;
  wire wr_out = wr_fire && wpage == `PAGE_OUT_POINT && wstrb_r[0];
  wire wr_preset = wr_fire && wpage == `PAGE_PRESET && wstrb_r[0];
  wire wr_trig = wr_fire && wpage == `PAGE_IN_FIELD && widx == `WORD_THIRD;
  wire wr_roll = w_first && wpage == `PAGE_ROLLOVER;
  wire wr_sense = w_first && wpage == `PAGE_SENSE;
  wire wr_ovr = wr_fire && wpage == `PAGE_SENSE && widx == `WORD_SECOND;
  wire wr_unmask = w_first && wpage == `PAGE_UNMASK;
  wire wr_cfg = wr_fire && wpage == `PAGE_CARD && widx == `WORD_SECOND;
  wire wr_inten = wr_fire && wpage == `PAGE_CARD && widx == `WORD_FIFTH && wstrb_r[0];

  // ---------------------------------------------
  // read decode
  // ---------------------------------------------
  logic rvalid_r;
  logic [1:0] rresp_r;
  word_type rdata_r;

  assign arready = ~rvalid_r;
  assign rvalid = rvalid_r;
  assign rresp = rresp_r;
  assign rdata = rdata_r;
  wire rd_fire = arvalid & arready;
  wire [5:0] rpage = araddr[`PAGE_MSB:`PAGE_LSB];
  wire [3:0] ridx = araddr[`WORD_MSB:`WORD_LSB];
  wire rd_ok = mapped(rpage, ridx);
  wire rd_irq = rd_fire && rpage == `PAGE_CARD && ridx == `WORD_FIRST;
  wire rd_plain = rd_fire && rpage == `PAGE_IN_FIELD && ridx == `WORD_FIRST;
  wire rd_strobe = rd_fire && rpage == `PAGE_IN_FIELD && ridx == `WORD_SECOND;

  // ---------------------------------------------
  // event scan
  // ---------------------------------------------
  wire tick = step_r == STEP_LAST;
  wire cur = in_s_r[scan_r];
  wire chg = cur != past_r[scan_r];
  wire dir_ok = ovr_r[scan_r] | (cur == sense_r[scan_r]);
  wire ev_now = tick & chg & dir_ok;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      step_r <= 6'h00;
      scan_r <= 4'h0;
    end
    else
    begin
      step_r <= tick ? 6'h00 : step_r + 6'h01;
      scan_r <= tick ? scan_r + 4'h1 : scan_r;
    end
  end

  // ---------------------------------------------
  // per-point counters
  // ---------------------------------------------
  count_type [15:0] count_nxt;
  count_type [15:0] preset_nxt;
  field_type past_nxt;
  field_type scaled;

  genvar gi;
  generate
    for (gi = 0; gi < `POINTS; gi++)
    begin : g_point
      wire here = scan_r == point_type'(gi);
      wire hit = ev_now & here;
      wire top = count_r[gi] == `COUNT_MAX;
      wire pre_wr = wr_preset && widx == point_type'(gi);
      wire count_type wrap = roll_r[gi] ? preset_r[gi] : `COUNT_ZERO;
      assign scaled[gi] = hit & top;
      assign count_nxt[gi] = pre_wr ? wdata_r[7:0] :
                             hit ? (top ? wrap : count_r[gi] + 8'h01) : count_r[gi];
      assign preset_nxt[gi] = pre_wr ? wdata_r[7:0] : preset_r[gi];
      assign past_nxt[gi] = (tick & here) ? in_s_r[gi] : past_r[gi];
    end
  endgenerate

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      count_r <= '0;
      preset_r <= '0;
      past_r <= `RST_FIELD;
    end
    else
    begin
      count_r <= count_nxt;
      preset_r <= preset_nxt;
      past_r <= past_nxt;
    end
  end

  // ---------------------------------------------
  // interrupt record
  // ---------------------------------------------
  wire field_type set_bits = scaled & unmask_r;
  wire any_set = |set_bits;
  wire field_type rec_view = rec_r | set_bits;
  wire field_type rec_nxt = rd_irq ? set_bits : rec_view;
  wire flag_first = any_set & (rec_r == `RST_FIELD);
  wire flag_nxt = rd_irq ? any_set : (flag_r | flag_first);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rec_r <= `RST_FIELD;
      flag_r <= 1'b0;
      irq_r <= 1'b0;
    end
    else
    begin
      rec_r <= rec_nxt;
      flag_r <= flag_nxt;
      irq_r <= flag_r & inten_r;
    end
  end

  assign card_irq = irq_r;

  // ---------------------------------------------
  // strobed input latch
  // ---------------------------------------------
  wire int_mode = ~cfg_r[`CFG_EXT_BIT];
  wire ext_edge = cfg_r[`CFG_RISE_BIT] ? ext_rise : ext_fall;
  wire latch_ext = ~int_mode & ~full_r & ext_edge;
  wire latch_trig = int_mode & ~full_r & wr_trig;
  wire latch_rdw = int_mode & ~full_r & rd_strobe;
  wire latch_any = latch_ext | latch_trig | latch_rdw;
  wire rd_stored = rd_plain | rd_strobe;
  wire field_type stored_nxt = latch_any ? in_s_r : stored_r;
  wire field_type in_field_view = latch_rdw ? in_s_r : stored_r;
  wire full_nxt = (latch_ext | latch_trig) ? 1'b1 : (rd_stored ? 1'b0 : full_r);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      stored_r <= `RST_FIELD;
      full_r <= 1'b0;
    end
    else
    begin
      stored_r <= stored_nxt;
      full_r <= full_nxt;
    end
  end

  // ---------------------------------------------
  // software registers
  // ---------------------------------------------
  wire field_type out_nxt = wr_out ? (out_r & ~(16'h0001 << widx)) | (16'(wdata_r[0]) << widx) : out_r;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      out_r <= `RST_FIELD;
      roll_r <= `RST_FIELD;
      sense_r <= `RST_FIELD;
      ovr_r <= `RST_FIELD;
      unmask_r <= `RST_FIELD;
      cfg_r <= `RST_CFG;
      inten_r <= 1'b0;
    end
    else
    begin
      out_r <= out_nxt;
      if (wr_roll)
        roll_r <= merge16(roll_r, wdata_r, wstrb_r[1:0]);
      if (wr_sense)
        sense_r <= merge16(sense_r, wdata_r, wstrb_r[1:0]);
      if (wr_ovr)
        ovr_r <= merge16(ovr_r, wdata_r, wstrb_r[1:0]);
      if (wr_unmask)
        unmask_r <= merge16(unmask_r, wdata_r, wstrb_r[1:0]);
      if (wr_cfg)
        cfg_r <= {23'h000000, wstrb_r[1] ? wdata_r[8] : cfg_r[8], 7'h00, wstrb_r[0] ? wdata_r[0] : cfg_r[0]};
      if (wr_inten)
        inten_r <= wdata_r[0];
    end
  end

  assign field_out = out_r;

  // ---------------------------------------------
  // read data selection
  // ---------------------------------------------
  wire word_type d_card = (ridx == `WORD_FIRST) ? {16'h0000, rec_view} :
                          (ridx == `WORD_SECOND) ? cfg_r :
                          (ridx == `WORD_THIRD) ? {31'h0, ~full_r} :
                          (ridx == `WORD_FOURTH) ? CARD_ID :
                          {31'h0, inten_r};
  wire word_type d_sense = (ridx == `WORD_FIRST) ? {16'h0000, sense_r} : {16'h0000, ovr_r};
  wire word_type d_in_field = (ridx == `WORD_THIRD) ? 32'h0000_0000 : {16'h0000, in_field_view};
  wire word_type rd_val =
    (rpage == `PAGE_IN_POINT) ? {31'h0, in_s_r[ridx]} :
    (rpage == `PAGE_OUT_POINT) ? {31'h0, out_r[ridx]} :
    (rpage == `PAGE_COUNT) ? {24'h000000, count_r[ridx]} :
    (rpage == `PAGE_PRESET) ? {24'h000000, preset_r[ridx]} :
    (rpage == `PAGE_IN_FIELD) ? d_in_field :
    (rpage == `PAGE_OUT_FIELD) ? {16'h0000, out_r} :
    (rpage == `PAGE_ROLLOVER) ? {16'h0000, roll_r} :
    (rpage == `PAGE_SENSE) ? d_sense :
    (rpage == `PAGE_UNMASK) ? {16'h0000, unmask_r} :
    d_card;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_r <= 1'b0;
      rresp_r <= `RESP_OKAY;
      rdata_r <= 32'h0000_0000;
    end
    else if (rd_fire)
    begin
      rvalid_r <= 1'b1;
      rresp_r <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
      rdata_r <= rd_ok ? rd_val : 32'h0000_0000;
    end
    else if (rready)
      rvalid_r <= 1'b0;
  end

endmodule

// ---- verification/dio_props.sv ----
// bus and field port checks for the event counter card
// assumes a bind to the card top, all checks on the aclk rising edge
`timescale 1ns/1ps
`include "digital_input_event_counter_map.svh"
module dio_props
  import dio_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [1:0] bresp,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [11:0] araddr,
  input wire logic rvalid,
  input wire logic rready,
  input wire word_type rdata,
  input wire logic [1:0] rresp,
  // field pins
  input wire field_type field_out
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ----------------------------------------
  // sequences
  // ----------------------------------------
  sequence s_ar(p);
    arvalid && arready && araddr[11:6] == p;
  endsequence
  sequence s_wr;
    awvalid && awready && wvalid && wready;
  endsequence
  // ----------------------------------------
  // properties
  // ----------------------------------------
  property p_wr_resp;
    s_wr |=> ##1 bvalid;
  endproperty
  property p_b_hold;
    bvalid && !bready |=> bvalid && $stable(bresp);
  endproperty
  property p_rd_resp;
    arvalid && arready |=> rvalid;
  endproperty
  property p_r_hold;
    rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp);
  endproperty
  property p_busy;
    (rvalid |-> !arready) and (bvalid |-> !awready && !wready);
  endproperty
  property p_unmapped;
    s_ar(6'h02) |=> rresp == `RESP_SLVERR && rdata == 32'h0;
  endproperty
  property p_out_point;
    s_ar(`PAGE_OUT_POINT) |=> rdata == {31'h0, $past(field_out[araddr[5:2]])};
  endproperty
  property p_out_field;
    s_ar(`PAGE_OUT_FIELD) ##0 araddr[5:2] == 4'h0 |=> rdata == {16'h0, $past(field_out)};
  endproperty
  property p_out_write;
    $changed(field_out) |-> bvalid;
  endproperty
  a_wr_resp: assert property (p_wr_resp) else $error("write response missing");
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  a_rd_resp: assert property (p_rd_resp) else $error("read response missing");
  a_r_hold: assert property (p_r_hold) else $error("read response dropped");
  a_busy: assert property (p_busy) else $error("ready while response pending");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read answered");
  a_out_point: assert property (p_out_point) else $error("output point readback wrong");
  a_out_field: assert property (p_out_field) else $error("output field readback wrong");
  a_out_write: assert property (p_out_write) else $error("output moved without write");
endmodule

// ---- verification/dio_field_model.sv ----
// field wiring and external strobe source for the event counter card
// assumes the bench sets wanted levels just after a rising edge
`timescale 1ns/1ps
module dio_field_model
  import dio_pkg::*;
(
  // clock
  input wire logic aclk,
  // wanted levels
  input wire field_type level,
  input wire logic strobe_req,
  // pins
  output field_type field_in = 16'h0000,
  output logic ext_strobe = 1'b0
);
  always @(posedge aclk)
  begin
    field_in <= level;
    ext_strobe <= strobe_req;
  end
endmodule

// ---- verification/tb_top.sv ----
// self-checking bench for the event counter card
// assumes dio_props and dio_field_model compiled first
`timescale 1ns/1ps
`include "digital_input_event_counter_map.svh"
module tb_top;
  import dio_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, strobe_req = 1'b0;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  word_type wdata = 32'h0, rdata;
  logic awready, wready, bvalid, arready, rvalid, card_irq, ext_strobe;
  logic [1:0] bresp, rresp;
  field_type level = 16'h0000, field_in, field_out;
  int bad_count = 0;
  int comparisons = 0;
  always #12.5 aclk = ~aclk;
  digital_input_event_counter uut (.aclk(aclk), .aresetn(aresetn),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awprot(3'h0),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(4'hF),
    .bvalid(bvalid), .bready(1'b1), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(3'h0),
    .rvalid(rvalid), .rready(1'b1), .rdata(rdata), .rresp(rresp),
    .field_in(field_in), .ext_strobe(ext_strobe), .field_out(field_out), .card_irq(card_irq));
  dio_field_model u_field (.aclk(aclk), .level(level), .strobe_req(strobe_req),
    .field_in(field_in), .ext_strobe(ext_strobe));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic check(input string name, input word_type seen, input word_type exp);
    comparisons++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  function automatic logic [11:0] ad(input logic [5:0] p, input logic [3:0] w);
    return {p, w, 2'b00};
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic wr(input logic [11:0] a, input word_type d);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1 && n < 50);
    check("bvalid", word_type'(bvalid), 32'h1);
    check("bresp", word_type'(bresp), (a[11:6] == 6'h02) ? 32'h2 : 32'h0);
  endtask
  task automatic rd(input string name, input logic [11:0] a, input word_type exp);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (arready) arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1 && n < 50);
    check(name, rdata, exp);
    check("rresp", word_type'(rresp), (a[11:6] == 6'h02) ? 32'h2 : 32'h0);
  endtask
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial
  begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd("config", ad(`PAGE_CARD, `WORD_SECOND), `RST_CFG);
    rd("state", ad(`PAGE_CARD, `WORD_THIRD), 32'h1);
    rd("record", ad(`PAGE_CARD, `WORD_FIRST), 32'h0);
    rd("unmapped", ad(6'h02, 4'h0), 32'h0);
    wr(ad(6'h02, 4'h0), 32'h1);
    $display("test reset done");
    for (int i = 0; i < 16; i++)
      wr(ad(`PAGE_OUT_POINT, 4'(i)), 32'hFFFF_FFF0 | 32'(i % 2));
    rd("output field", ad(`PAGE_OUT_FIELD, 4'h0), 32'h0000_AAAA);
    rd("output point", ad(`PAGE_OUT_POINT, 4'h3), 32'h1);
    check("field_out", word_type'(field_out), 32'h0000_AAAA);
    $display("test outputs done");
    wr(ad(`PAGE_ROLLOVER, 4'h0), 32'h1);
    wr(ad(`PAGE_SENSE, 4'h0), 32'h2);
    wr(ad(`PAGE_SENSE, 4'h1), 32'h5);
    wr(ad(`PAGE_UNMASK, 4'h0), 32'h3);
    wr(ad(`PAGE_PRESET, 4'h0), 32'd253);
    wr(ad(`PAGE_PRESET, 4'h1), 32'd252);
    wr(ad(`PAGE_PRESET, 4'h2), 32'd255);
    rd("preset", ad(`PAGE_PRESET, 4'h1), 32'd252);
    rd("count0", ad(`PAGE_COUNT, 4'h0), 32'd253);
    for (int k = 1; k <= 8; k++)
    begin
      level <= (k % 2) ? 16'h0007 : 16'h0000;
      cyc(700);
    end
    rd("count0", ad(`PAGE_COUNT, 4'h0), 32'd255);
    rd("count1", ad(`PAGE_COUNT, 4'h1), 32'd0);
    rd("count2", ad(`PAGE_COUNT, 4'h2), 32'd7);
    check("irq off", word_type'(card_irq), 32'h0);
    wr(ad(`PAGE_CARD, `WORD_FIFTH), 32'h1);
    cyc(3);
    check("irq on", word_type'(card_irq), 32'h1);
    rd("record", ad(`PAGE_CARD, `WORD_FIRST), 32'h3);
    rd("cleared", ad(`PAGE_CARD, `WORD_FIRST), 32'h0);
    cyc(3);
    check("irq clear", word_type'(card_irq), 32'h0);
    $display("test events done");
    level <= 16'hC000;
    cyc(10);
    rd("input point 15", ad(`PAGE_IN_POINT, 4'hF), 32'h1);
    rd("input point 0", ad(`PAGE_IN_POINT, 4'h0), 32'h0);
    rd("strobed", ad(`PAGE_IN_FIELD, `WORD_SECOND), 32'hC000);
    wr(ad(`PAGE_IN_FIELD, `WORD_THIRD), 32'h0);
    rd("state", ad(`PAGE_CARD, `WORD_THIRD), 32'h0);
    level <= 16'h3000;
    cyc(10);
    rd("locked", ad(`PAGE_IN_FIELD, `WORD_SECOND), 32'hC000);
    wr(ad(`PAGE_IN_FIELD, `WORD_THIRD), 32'h0);
    rd("stored", ad(`PAGE_IN_FIELD, `WORD_FIRST), 32'h3000);
    wr(ad(`PAGE_CARD, `WORD_SECOND), 32'h101);
    rd("config", ad(`PAGE_CARD, `WORD_SECOND), 32'h101);
    level <= 16'h0A00;
    wr(ad(`PAGE_IN_FIELD, `WORD_THIRD), 32'h0);
    rd("no trigger", ad(`PAGE_CARD, `WORD_THIRD), 32'h1);
    strobe_req <= 1'b1;
    cyc(10);
    rd("ext state", ad(`PAGE_CARD, `WORD_THIRD), 32'h0);
    level <= 16'h0500;
    strobe_req <= 1'b0;
    cyc(10);
    strobe_req <= 1'b1;
    cyc(10);
    rd("ext data", ad(`PAGE_IN_FIELD, `WORD_FIRST), 32'h0A00);
    strobe_req <= 1'b0;
    cyc(10);
    rd("fall skip", ad(`PAGE_CARD, `WORD_THIRD), 32'h1);
    wr(ad(`PAGE_CARD, `WORD_SECOND), 32'h1);
    strobe_req <= 1'b1;
    cyc(10);
    rd("rise skip", ad(`PAGE_CARD, `WORD_THIRD), 32'h1);
    strobe_req <= 1'b0;
    cyc(10);
    rd("fall data", ad(`PAGE_IN_FIELD, `WORD_FIRST), 32'h0500);
    $display("test strobe done");
    report_and_stop();
  end
  initial
  begin
    repeat (20000) @(posedge aclk);
    bad_count++;
    report_and_stop();
  end
endmodule
bind digital_input_event_counter dio_props u_props (.aclk(aclk), .aresetn(aresetn),
  .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready),
  .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
  .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
  .field_out(field_out));
